// *** hdl/cpurm_consts.vh ***
// constants for the cpu programmer register model: offsets, fields, reset values, commands
`ifndef CPURM_CONSTS_VH
`define CPURM_CONSTS_VH

// apb byte offsets, one aligned word each
`define CPURM_OFS_ACC        8'h00
`define CPURM_OFS_IDX_HI     8'h04
`define CPURM_OFS_IDX_LO     8'h08
`define CPURM_OFS_STACK      8'h0c
`define CPURM_OFS_PC         8'h10
`define CPURM_OFS_FLAGS      8'h14
`define CPURM_OFS_OPERAND    8'h18
`define CPURM_OFS_CMD        8'h1c
`define CPURM_OFS_STATUS     8'h20
`define CPURM_OFS_EFF_ADDR   8'h24
`define CPURM_OFS_STACK_ADDR 8'h28

// condition flag bit positions
`define CPURM_FLAG_V         7
`define CPURM_FLAG_ONE6      6
`define CPURM_FLAG_ONE5      5
`define CPURM_FLAG_H         4
`define CPURM_FLAG_I         3
`define CPURM_FLAG_N         2
`define CPURM_FLAG_Z         1
`define CPURM_FLAG_C         0
`define CPURM_FLAG_FIXED     8'h60

// reset values
`define CPURM_RST_IDX_HI     8'h00
`define CPURM_RST_STACK      16'h00ff
`define CPURM_RST_FLAGS      8'h08
`define CPURM_RST_PC         16'h0000

// reset vector location, high byte first
`define CPURM_VEC_HI_ADDR    16'hfffe
`define CPURM_VEC_LO_ADDR    16'hffff

// bytes stacked on interrupt entry: pc low, pc high, index low, accumulator, flags
`define CPURM_IRQ_STACK_LEN  3'h5

// command codes written to the command register
`define CPURM_CMD_NOP        5'h00
`define CPURM_CMD_ADD        5'h01
`define CPURM_CMD_ADC        5'h02
`define CPURM_CMD_SUB        5'h03
`define CPURM_CMD_BCD        5'h04
`define CPURM_CMD_LOAD       5'h05
`define CPURM_CMD_SADD       5'h06
`define CPURM_CMD_STKL       5'h07
`define CPURM_CMD_CLRI       5'h08
`define CPURM_CMD_SEI        5'h09
`define CPURM_CMD_TAP        5'h0a
`define CPURM_CMD_PUSH       5'h0b
`define CPURM_CMD_PULL       5'h0c
`define CPURM_CMD_FETCH      5'h0d
`define CPURM_CMD_BRANCH     5'h0e
`define CPURM_CMD_BOUNDARY   5'h0f
`define CPURM_CMD_SHIFT_R    5'h10
`define CPURM_CMD_STORE      5'h11

// status register fields
`define CPURM_ST_BOOT_DONE   0
`define CPURM_ST_IRQ_BUSY    1
`define CPURM_ST_INHIBIT     2
`define CPURM_ST_IRQ_REQ     3

`endif

// *** hdl/cpurm_regs.v ***
// cpu programmer register model with apb slave, reset-vector fetch and interrupt mask timing
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
// What this block does
// - reset never clears or loads the accumulator
// - reset forces index high byte to zero
// - index low byte keeps its contents across reset
// - reset loads stack pointer with 0x00ff
// - after reset, program counter loads vector from 0xfffe/0xffff, high byte first
// - program counter steps on each fetch unless a flow change loads it
// - stack pointer addresses next free stack byte anywhere in 64k
// - add-immediate-to-stack sign-extends the 8-bit operand and adds it
// - stack low byte reset changes only the low byte
// - indexed addressing uses full 16-bit index pair, high byte on top
// - flag bits 6 and 5 read one and ignore writes
// - bit 7 flags two's complement overflow on add and subtract; the branch command does not test it
// - bit 4 catches carry from bit 3 into bit 4 on add
// - decimal adjust uses half-carry and carry to correct bcd sums
// - mask bit one blocks maskable interrupts, zero accepts them
// - on interrupt entry mask is set after stacking, before service code
// - after an instruction clears the mask, next boundary takes no interrupt
// - bit 2 follows result msb, loads and stores included
// - bit 1 set when result, load or store value is zero
// - bit 0 carries out of bit 7 on add, borrow on subtract, shifts
`include "cpurm_consts.vh"

module cpurm_regs (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         mem_rd,
  output reg  [15:0] mem_addr,
  input  wire [7:0]  mem_rdata,
  input  wire        irq_req,
  output reg         irq_accept,
  output wire [15:0] index_pointer,
  output wire [15:0] stack_pointer,
  output wire [15:0] program_counter
);

  ////////////////////////////////////////////////////////////////////////////
  // state codes
  localparam [1:0] BOOT_HI   = 2'h0;
  localparam [1:0] BOOT_LO   = 2'h1;
  localparam [1:0] BOOT_CAP  = 2'h2;
  localparam [1:0] BOOT_RUN  = 2'h3;

  localparam [1:0] IRQ_IDLE  = 2'h0;
  localparam [1:0] IRQ_STACK = 2'h1;
  localparam [1:0] IRQ_MASK  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // 8-bit add with carry in; returns {v, h, c, sum}
  function [10:0] add8;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [8:0] s;
    reg   [4:0] lo;
    begin
      s     = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      add8  = {(a[7] == b[7]) && (s[7] != a[7]), lo[4], s[8], s[7:0]};
    end
  endfunction

  // negative and zero of an 8-bit value; returns {n, z}
  function [1:0] nz8;
    input [7:0] v;
    begin
      nz8 = {v[7], (v == 8'h00)};
    end
  endfunction

  // sign extension of an 8-bit offset
  function [15:0] sext8;
    input [7:0] v;
    begin
      sext8 = {{8{v[7]}}, v};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0]  acc_reg;
  reg  [7:0]  acc_next;
  reg  [7:0]  idx_lo_reg;
  reg  [7:0]  idx_lo_next;
  reg  [7:0]  idx_hi_reg;
  reg  [7:0]  idx_hi_next;
  reg  [15:0] sp_reg;
  reg  [15:0] sp_next;
  reg  [15:0] pc_reg;
  reg  [15:0] pc_next;
  reg  [7:0]  flags_reg;
  reg  [7:0]  flags_next;
  reg  [7:0]  operand_reg;
  reg  [7:0]  operand_next;
  reg  [15:0] stack_addr_reg;
  reg  [15:0] stack_addr_next;
  reg         inhibit_reg;
  reg         inhibit_next;
  reg  [1:0]  boot_reg;
  reg  [1:0]  boot_next;
  reg  [7:0]  vec_hi_reg;
  reg  [7:0]  vec_hi_next;
  reg  [1:0]  irq_reg;
  reg  [1:0]  irq_next;
  reg  [2:0]  irq_cnt_reg;
  reg  [2:0]  irq_cnt_next;

  wire        wr_en;
  wire        rd_setup;
  wire        mapped;
  wire        busy;
  wire        cmd_go;
  wire [4:0]  cmd;
  wire [15:0] eff_addr;
  reg  [31:0] rd_mux;
  reg  [10:0] alu;
  reg  [7:0]  bcd_corr;
  reg         bcd_carry;
  reg  [8:0]  bcd_sum;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, unmapped offsets answer with an error
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= `CPURM_OFS_STACK_ADDR);
  assign pslverr  = psel && penable && !mapped;

  // commands are dropped while boot or interrupt entry owns the registers
  assign busy     = (boot_reg != BOOT_RUN) || (irq_reg != IRQ_IDLE);
  assign cmd_go   = wr_en && (paddr == `CPURM_OFS_CMD) && !busy;
  assign cmd      = pwdata[4:0];

  assign eff_addr        = {idx_hi_reg, idx_lo_reg} + {8'h00, operand_reg};
  assign index_pointer   = {idx_hi_reg, idx_lo_reg};
  assign stack_pointer   = sp_reg;
  assign program_counter = pc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; fixed flag bits always read one
  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `CPURM_OFS_ACC:        rd_mux = {24'h000000, acc_reg};
      `CPURM_OFS_IDX_HI:     rd_mux = {24'h000000, idx_hi_reg};
      `CPURM_OFS_IDX_LO:     rd_mux = {24'h000000, idx_lo_reg};
      `CPURM_OFS_STACK:      rd_mux = {16'h0000, sp_reg};
      `CPURM_OFS_PC:         rd_mux = {16'h0000, pc_reg};
      `CPURM_OFS_FLAGS:      rd_mux = {24'h000000, flags_reg | `CPURM_FLAG_FIXED};
      `CPURM_OFS_OPERAND:    rd_mux = {24'h000000, operand_reg};
      `CPURM_OFS_STATUS:     rd_mux = {28'h0000000, irq_req, inhibit_reg, (irq_reg != IRQ_IDLE),
                                       (boot_reg == BOOT_RUN)};
      `CPURM_OFS_EFF_ADDR:   rd_mux = {16'h0000, eff_addr};
      `CPURM_OFS_STACK_ADDR: rd_mux = {16'h0000, stack_addr_reg};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle so it comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers shared by the command decode
  always @* begin
    alu       = 11'h000;
    bcd_corr  = 8'h00;
    bcd_carry = flags_reg[`CPURM_FLAG_C];
    case (cmd)
      `CPURM_CMD_ADD: alu = add8(acc_reg, operand_reg, 1'b0);
      `CPURM_CMD_ADC: alu = add8(acc_reg, operand_reg, flags_reg[`CPURM_FLAG_C]);
      `CPURM_CMD_SUB: alu = add8(acc_reg, ~operand_reg, 1'b1);
      default:        alu = 11'h000;
    endcase
    // bcd correction: six in the low nibble on half-carry or past nine, six in the high nibble on carry or a byte past 0x99
    if (flags_reg[`CPURM_FLAG_H] || (acc_reg[3:0] > 4'h9)) begin
      bcd_corr[3:0] = 4'h6;
    end
    if (flags_reg[`CPURM_FLAG_C] || (acc_reg > 8'h99)) begin
      bcd_corr[7:4] = 4'h6;
      bcd_carry     = 1'b1;
    end
    bcd_sum = {1'b0, acc_reg} + {1'b0, bcd_corr};
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for the programmer-visible registers
  always @* begin
    acc_next        = acc_reg;
    idx_lo_next     = idx_lo_reg;
    idx_hi_next     = idx_hi_reg;
    sp_next         = sp_reg;
    pc_next         = pc_reg;
    flags_next      = flags_reg;
    operand_next    = operand_reg;
    stack_addr_next = stack_addr_reg;
    inhibit_next    = inhibit_reg;
    boot_next       = boot_reg;
    vec_hi_next     = vec_hi_reg;
    irq_next        = irq_reg;
    irq_cnt_next    = irq_cnt_reg;
    irq_accept      = 1'b0;
    mem_rd          = 1'b0;
    mem_addr        = 16'h0000;

    // direct software writes
    if (wr_en) begin
      case (paddr)
        `CPURM_OFS_ACC:     acc_next     = pwdata[7:0];
        `CPURM_OFS_IDX_HI:  idx_hi_next  = pwdata[7:0];
        `CPURM_OFS_IDX_LO:  idx_lo_next  = pwdata[7:0];
        `CPURM_OFS_STACK:   sp_next      = pwdata[15:0];
        `CPURM_OFS_PC:      pc_next      = pwdata[15:0];
        `CPURM_OFS_FLAGS:   flags_next   = pwdata[7:0] & ~`CPURM_FLAG_FIXED;
        `CPURM_OFS_OPERAND: operand_next = pwdata[7:0];
        default:            operand_next = operand_reg;
      endcase
    end

    // reset vector fetch, one byte a cycle, data back the cycle after
    case (boot_reg)
      BOOT_HI: begin
        mem_rd    = 1'b1;
        mem_addr  = `CPURM_VEC_HI_ADDR;
        boot_next = BOOT_LO;
      end
      BOOT_LO: begin
        mem_rd      = 1'b1;
        mem_addr    = `CPURM_VEC_LO_ADDR;
        vec_hi_next = mem_rdata;
        boot_next   = BOOT_CAP;
      end
      BOOT_CAP: begin
        pc_next   = {vec_hi_reg, mem_rdata};
        boot_next = BOOT_RUN;
      end
      default: boot_next = BOOT_RUN;
    endcase

    // interrupt entry: stack five bytes, then raise the mask
    case (irq_reg)
      IRQ_STACK: begin
        stack_addr_next = sp_reg;
        sp_next         = sp_reg - 16'h0001;
        irq_cnt_next    = irq_cnt_reg - 3'h1;
        if (irq_cnt_reg == 3'h1) begin
          irq_next = IRQ_MASK;
        end
      end
      IRQ_MASK: begin
        flags_next[`CPURM_FLAG_I] = 1'b1;
        irq_next                  = IRQ_IDLE;
      end
      default: irq_next = IRQ_IDLE;
    endcase

    // command execution
    if (cmd_go) begin
      case (cmd)
        `CPURM_CMD_ADD, `CPURM_CMD_ADC: begin
          acc_next                  = alu[7:0];
          flags_next[`CPURM_FLAG_V] = alu[10];
          flags_next[`CPURM_FLAG_H] = alu[9];
          flags_next[`CPURM_FLAG_C] = alu[8];
          {flags_next[`CPURM_FLAG_N], flags_next[`CPURM_FLAG_Z]} = nz8(alu[7:0]);
        end
        `CPURM_CMD_SUB: begin
          acc_next                  = alu[7:0];
          flags_next[`CPURM_FLAG_V] = alu[10];
          flags_next[`CPURM_FLAG_C] = !alu[8];
          flags_next[`CPURM_FLAG_N] = alu[7];
          flags_next[`CPURM_FLAG_Z] = (alu[7:0] == 8'h00);
        end
        `CPURM_CMD_BCD: begin
          acc_next                  = bcd_sum[7:0];
          flags_next[`CPURM_FLAG_C] = bcd_carry;
          flags_next[`CPURM_FLAG_N] = bcd_sum[7];
          flags_next[`CPURM_FLAG_Z] = (bcd_sum[7:0] == 8'h00);
        end
        `CPURM_CMD_LOAD: begin
          acc_next                  = operand_reg;
          flags_next[`CPURM_FLAG_V] = 1'b0;
          flags_next[`CPURM_FLAG_N] = operand_reg[7];
          flags_next[`CPURM_FLAG_Z] = (operand_reg == 8'h00);
        end
        `CPURM_CMD_STORE: begin
          // store of the accumulator: flags follow the stored value
          flags_next[`CPURM_FLAG_V] = 1'b0;
          flags_next[`CPURM_FLAG_N] = acc_reg[7];
          flags_next[`CPURM_FLAG_Z] = (acc_reg == 8'h00);
        end
        `CPURM_CMD_SHIFT_R: begin
          acc_next                  = {1'b0, acc_reg[7:1]};
          flags_next[`CPURM_FLAG_C] = acc_reg[0];
          flags_next[`CPURM_FLAG_N] = 1'b0;
          flags_next[`CPURM_FLAG_Z] = (acc_reg[7:1] == 7'h00);
          flags_next[`CPURM_FLAG_V] = acc_reg[0];
        end
        `CPURM_CMD_SADD: begin
          sp_next = sp_reg + sext8(operand_reg);
        end
        `CPURM_CMD_STKL: begin
          sp_next = {sp_reg[15:8], 8'hff};
        end
        `CPURM_CMD_CLRI: begin
          flags_next[`CPURM_FLAG_I] = 1'b0;
          inhibit_next              = flags_reg[`CPURM_FLAG_I];
        end
        `CPURM_CMD_SEI: begin
          flags_next[`CPURM_FLAG_I] = 1'b1;
        end
        `CPURM_CMD_TAP: begin
          flags_next   = acc_reg & ~`CPURM_FLAG_FIXED;
          inhibit_next = flags_reg[`CPURM_FLAG_I] && !acc_reg[`CPURM_FLAG_I];
        end
        `CPURM_CMD_PUSH: begin
          stack_addr_next = sp_reg;
          sp_next         = sp_reg - 16'h0001;
        end
        `CPURM_CMD_PULL: begin
          stack_addr_next = sp_reg + 16'h0001;
          sp_next         = sp_reg + 16'h0001;
        end
        `CPURM_CMD_FETCH: begin
          pc_next = pc_reg + 16'h0001;
        end
        `CPURM_CMD_BRANCH: begin
          pc_next = pc_reg + sext8(operand_reg);
        end
        `CPURM_CMD_BOUNDARY: begin
          // one instruction always runs after CLRI or TAP clears the mask; a direct flags write sets no inhibit
          inhibit_next = 1'b0;
          if (irq_req && !flags_reg[`CPURM_FLAG_I] && !inhibit_reg) begin
            irq_accept   = 1'b1;
            irq_next     = IRQ_STACK;
            irq_cnt_next = `CPURM_IRQ_STACK_LEN;
          end
        end
        default: inhibit_next = inhibit_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator and index low byte have no reset at all
  always @(posedge pclk) begin
    acc_reg    <= acc_next;
    idx_lo_reg <= idx_lo_next;
  end

  // everything else resets asynchronously to constants
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_hi_reg     <= `CPURM_RST_IDX_HI;
      sp_reg         <= `CPURM_RST_STACK;
      pc_reg         <= `CPURM_RST_PC;
      flags_reg      <= `CPURM_RST_FLAGS;
      operand_reg    <= 8'h00;
      stack_addr_reg <= 16'h0000;
      inhibit_reg    <= 1'b0;
      boot_reg       <= BOOT_HI;
      vec_hi_reg     <= 8'h00;
      irq_reg        <= IRQ_IDLE;
      irq_cnt_reg    <= 3'h0;
    end else begin
      idx_hi_reg     <= idx_hi_next;
      sp_reg         <= sp_next;
      pc_reg         <= pc_next;
      flags_reg      <= flags_next;
      operand_reg    <= operand_next;
      stack_addr_reg <= stack_addr_next;
      inhibit_reg    <= inhibit_next;
      boot_reg       <= boot_next;
      vec_hi_reg     <= vec_hi_next;
      irq_reg        <= irq_next;
      irq_cnt_reg    <= irq_cnt_next;
    end
  end

endmodule

// *** dv/cpurm_props.sv ***
// port assertions for the cpu register model
`timescale 1ns/10ps
`include "cpurm_consts.vh"
module cpurm_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        mem_rd,
  input logic [15:0] mem_addr,
  input logic [7:0]  mem_rdata,
  input logic        irq_req,
  input logic        irq_accept,
  input logic [15:0] index_pointer,
  input logic [15:0] stack_pointer,
  input logic [15:0] program_counter
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // shadows of operand, vector bytes and stack; commands count only after boot
  logic [7:0]  op_reg;
  logic [7:0]  vhi_reg;
  logic [7:0]  vlo_reg;
  logic [15:0] addr_reg;
  logic [15:0] sp_reg;
  logic        rd_reg;
  logic        boot_reg;
  wire         acc_ph = psel && penable;
  wire         cmd_wr = acc_ph && pwrite && paddr == `CPURM_OFS_CMD && boot_reg;
  wire [4:0]   cmd    = pwdata[4:0];
  wire [7:0]   sp_hi  = stack_pointer[15:8];
  // boot flag cleared by reset so a command during the vector fetch is not judged
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) boot_reg <= 1'b0;
    else if (!mem_rd) boot_reg <= 1'b1;
  end
  // memory answers one cycle late, so bytes are taken against last cycle's address
  always @(posedge pclk) begin
    rd_reg   <= mem_rd;
    addr_reg <= mem_addr;
    if (rd_reg && addr_reg == `CPURM_VEC_HI_ADDR) vhi_reg <= mem_rdata;
    if (rd_reg && addr_reg == `CPURM_VEC_LO_ADDR) vlo_reg <= mem_rdata;
    if (acc_ph && pwrite && paddr == `CPURM_OFS_OPERAND) op_reg <= pwdata[7:0];
    if (irq_accept) sp_reg <= stack_pointer;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_boot_addr_order: assert property ($rose(presetn) |-> mem_rd && mem_addr == `CPURM_VEC_HI_ADDR
    ##1 mem_rd && mem_addr == `CPURM_VEC_LO_ADDR) else $error("vector fetch order wrong");
  a_boot_vector_load: assert property ($fell(mem_rd) |-> ##[0:1] program_counter == {vhi_reg, vlo_reg})
    else $error("pc not loaded with vector");
  a_reset_stack_index: assert property ($rose(presetn) |-> stack_pointer == `CPURM_RST_STACK
    && index_pointer[15:8] == `CPURM_RST_IDX_HI) else $error("stack or index high wrong after reset");
  a_flags_fixed_ones: assert property (acc_ph && !pwrite && paddr == `CPURM_OFS_FLAGS |-> prdata[6:5] == 2'b11)
    else $error("flag bits 6 and 5 not one");
  a_stack_low_only: assert property (cmd_wr && cmd == `CPURM_CMD_STKL |=> sp_hi == $past(sp_hi)
    && stack_pointer[7:0] == 8'hff) else $error("stack low reset wrong");
  a_stack_sign_ext: assert property (cmd_wr && cmd == `CPURM_CMD_SADD
    |=> stack_pointer == $past(stack_pointer) + {{8{op_reg[7]}}, op_reg}) else $error("stack add wrong");
  a_fetch_step: assert property (cmd_wr && cmd == `CPURM_CMD_FETCH
    |=> program_counter == $past(program_counter) + 16'h0001) else $error("pc did not step");
  a_push_pull_step: assert property (cmd_wr && (cmd == `CPURM_CMD_PUSH || cmd == `CPURM_CMD_PULL)
    |=> stack_pointer == $past(stack_pointer) + ($past(cmd) == `CPURM_CMD_PUSH ? 16'hffff : 16'h0001))
    else $error("push or pull step wrong");
  a_accept_cause: assert property (irq_accept |-> cmd_wr && cmd == `CPURM_CMD_BOUNDARY && irq_req)
    else $error("interrupt taken without boundary and request");
  a_irq_stacking: assert property (irq_accept |-> ##7 stack_pointer == sp_reg - 16'h0005)
    else $error("interrupt entry did not stack five bytes");
  c_irq_taken: cover property (irq_accept);
  c_stack_add: cover property (cmd_wr && cmd == `CPURM_CMD_SADD);
  c_boot_done: cover property ($fell(mem_rd));
endmodule

bind cpurm_regs cpurm_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .irq_req(irq_req), .irq_accept(irq_accept),
  .index_pointer(index_pointer), .stack_pointer(stack_pointer), .program_counter(program_counter));

// *** dv/cpurm_mem_model.sv ***
// memory model holding the reset vector
`timescale 1ns/10ps
`include "cpurm_consts.vh"
module cpurm_mem_model (
  input  logic        pclk,
  input  logic        mem_rd,
  input  logic [15:0] mem_addr,
  input  logic [15:0] vector,
  output logic [7:0]  mem_rdata
);
  initial mem_rdata = 8'h00;
  // one cycle latency, high byte at the lower address; idle bus toggles so stale data never passes
  always @(posedge pclk) begin
    if (mem_rd && mem_addr == `CPURM_VEC_HI_ADDR) mem_rdata <= vector[15:8];
    else if (mem_rd && mem_addr == `CPURM_VEC_LO_ADDR) mem_rdata <= vector[7:0];
    else mem_rdata <= ~mem_rdata;
  end
endmodule

// *** dv/tb.sv ***
// self-checking bench for the cpu register model
`timescale 1ns/10ps
`include "cpurm_consts.vh"
module tb;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        irq_req = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [15:0] vector  = 16'h1357;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, mem_rd, irq_accept, err;
  logic [15:0] mem_addr, index_pointer, stack_pointer, program_counter;
  logic [7:0]  mem_rdata;
  int          failures = 0;
  int          check_count = 0;
  int          accepts = 0;
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 pclk = ~pclk;
  cpurm_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .irq_req(irq_req), .irq_accept(irq_accept),
    .index_pointer(index_pointer), .stack_pointer(stack_pointer), .program_counter(program_counter));
  cpurm_mem_model u_mem (.pclk(pclk), .mem_rd(mem_rd), .mem_addr(mem_addr), .vector(vector),
    .mem_rdata(mem_rdata));
  // accept pulses last one cycle, so they are counted at the edge
  always @(posedge pclk) if (irq_accept === 1'b1) accepts <= accepts + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // setup then access, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      complete_run();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // bounded poll on a status bit until it reads the wanted level
  task poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `CPURM_OFS_STATUS, 32'h0);
      n++;
    end while (rd[b] !== v && n < 20);
    if (n >= 20) begin
      failures++;
      complete_run();
    end
  endtask
  task do_reset(input logic [15:0] v);
    @(posedge pclk);
    presetn <= 1'b0;
    vector  <= v;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    poll(`CPURM_ST_BOOT_DONE, 1'b1);
  endtask
  task cmd_chk(input logic [7:0] o, input logic [4:0] c, input logic [7:0] a, input logic [15:0] e);
    wr(`CPURM_OFS_OPERAND, {24'h0, o});
    wr(`CPURM_OFS_CMD, {27'h0, c});
    rchk(a, {16'h0, e});
  endtask
  task alu(input logic [7:0] a, f, o, input logic [4:0] c, input logic [7:0] ea, ef, m);
    wr(`CPURM_OFS_FLAGS, {24'h0, f});
    wr(`CPURM_OFS_ACC, {24'h0, a});
    cmd_chk(o, c, `CPURM_OFS_ACC, {8'h0, ea});
    apb(1'b0, `CPURM_OFS_FLAGS, 32'h0);
    check(rd & {24'h0, m}, {24'h0, ef & m});
  endtask
  task boundary(input int k);
    wr(`CPURM_OFS_CMD, {27'h0, `CPURM_CMD_BOUNDARY});
    poll(`CPURM_ST_IRQ_BUSY, 1'b0);
    check(accepts, k);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    wr(`CPURM_OFS_ACC, 32'h5a);
    wr(`CPURM_OFS_IDX_LO, 32'hc3);
    wr(`CPURM_OFS_IDX_HI, 32'h77);
    wr(`CPURM_OFS_STACK, 32'h1234);
    do_reset(16'h8421);
    rchk(`CPURM_OFS_ACC, 32'h5a);
    rchk(`CPURM_OFS_IDX_LO, 32'hc3);
    rchk(`CPURM_OFS_IDX_HI, 32'h00);
    rchk(`CPURM_OFS_STACK, 32'h00ff);
    rchk(`CPURM_OFS_PC, 32'h8421);
    rchk(`CPURM_OFS_FLAGS, 32'h68);
    wr(`CPURM_OFS_FLAGS, 32'h00);
    rchk(`CPURM_OFS_FLAGS, 32'h60);
    $display("test reset done");
  endtask
  task t_alu;
    alu(8'h08, 8'h00, 8'h08, `CPURM_CMD_ADD, 8'h10, 8'h10, 8'h97);
    alu(8'h7f, 8'h00, 8'h01, `CPURM_CMD_ADD, 8'h80, 8'h94, 8'h97);
    alu(8'hff, 8'h00, 8'h01, `CPURM_CMD_ADD, 8'h00, 8'h13, 8'h97);
    alu(8'h0f, 8'h01, 8'h00, `CPURM_CMD_ADC, 8'h10, 8'h10, 8'h97);
    alu(8'h00, 8'h00, 8'h01, `CPURM_CMD_SUB, 8'hff, 8'h05, 8'h87);
    alu(8'h80, 8'h00, 8'h01, `CPURM_CMD_SUB, 8'h7f, 8'h80, 8'h87);
    alu(8'h3c, 8'h00, 8'h00, `CPURM_CMD_BCD, 8'h42, 8'h00, 8'h01);
    alu(8'h10, 8'h10, 8'h00, `CPURM_CMD_BCD, 8'h16, 8'h00, 8'h01);
    alu(8'h9a, 8'h00, 8'h00, `CPURM_CMD_BCD, 8'h00, 8'h01, 8'h01);
    alu(8'h20, 8'h01, 8'h00, `CPURM_CMD_BCD, 8'h80, 8'h01, 8'h01);
    alu(8'h00, 8'h00, 8'h80, `CPURM_CMD_LOAD, 8'h80, 8'h04, 8'h86);
    alu(8'h55, 8'h00, 8'h00, `CPURM_CMD_LOAD, 8'h00, 8'h02, 8'h86);
    alu(8'h01, 8'h00, 8'h00, `CPURM_CMD_SHIFT_R, 8'h00, 8'h83, 8'h87);
    alu(8'h80, 8'h02, 8'h00, `CPURM_CMD_STORE, 8'h80, 8'h04, 8'h86);
    alu(8'h00, 8'h00, 8'h00, `CPURM_CMD_STORE, 8'h00, 8'h02, 8'h86);
    $display("test alu flags done");
  endtask
  task t_stack;
    wr(`CPURM_OFS_STACK, 32'h1234);
    cmd_chk(8'h80, `CPURM_CMD_SADD, `CPURM_OFS_STACK, 16'h11b4);
    cmd_chk(8'h7f, `CPURM_CMD_SADD, `CPURM_OFS_STACK, 16'h1233);
    cmd_chk(8'h00, `CPURM_CMD_STKL, `CPURM_OFS_STACK, 16'h12ff);
    cmd_chk(8'h00, `CPURM_CMD_PUSH, `CPURM_OFS_STACK, 16'h12fe);
    rchk(`CPURM_OFS_STACK_ADDR, 32'h12ff);
    cmd_chk(8'h00, `CPURM_CMD_PULL, `CPURM_OFS_STACK, 16'h12ff);
    rchk(`CPURM_OFS_STACK_ADDR, 32'h12ff);
    wr(`CPURM_OFS_STACK, 32'h0000);
    cmd_chk(8'h00, `CPURM_CMD_PUSH, `CPURM_OFS_STACK, 16'hffff);
    wr(`CPURM_OFS_PC, 32'hffff);
    cmd_chk(8'h00, `CPURM_CMD_FETCH, `CPURM_OFS_PC, 16'h0000);
    cmd_chk(8'hfe, `CPURM_CMD_BRANCH, `CPURM_OFS_PC, 16'hfffe);
    wr(`CPURM_OFS_IDX_HI, 32'hab);
    wr(`CPURM_OFS_IDX_LO, 32'hcd);
    cmd_chk(8'h40, `CPURM_CMD_NOP, `CPURM_OFS_EFF_ADDR, 16'hac0d);
    check({16'h0, index_pointer}, 32'habcd);
    apb(1'b0, 8'h2c, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test stack and counter done");
  endtask
  task t_irq;
    wr(`CPURM_OFS_FLAGS, 32'h08);
    wr(`CPURM_OFS_STACK, 32'h0200);
    irq_req <= 1'b1;
    boundary(0);
    wr(`CPURM_OFS_CMD, {27'h0, `CPURM_CMD_CLRI});
    boundary(0);
    boundary(1);
    rchk(`CPURM_OFS_STACK, 32'h01fb);
    apb(1'b0, `CPURM_OFS_FLAGS, 32'h0);
    check(rd & 32'h08, 32'h08);
    wr(`CPURM_OFS_ACC, 32'h00);
    wr(`CPURM_OFS_CMD, {27'h0, `CPURM_CMD_TAP});
    boundary(1);
    boundary(2);
    irq_req <= 1'b0;
    $display("test interrupt mask done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(16'h1357);
    rchk(`CPURM_OFS_PC, 32'h1357);
    t_reset();
    t_alu();
    t_stack();
    t_irq();
    complete_run();
  end
  // hang guard, far above the whole sequence
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    complete_run();
  end
endmodule
